// *** rtl/qac_pkg.sv ***
// Purpose: shared constants and types of the converter config bank
// Assumes: 32-bit AXI4-Lite, 11-bit registers, 14-bit samples
// Notes: byte address is four times the register index
package qac_pkg;
  // ----------------------------------------
  // widths and register map
  // ----------------------------------------
  localparam int REG_W = 11;
  localparam int WORD_W = 14;
  localparam int UP_W = 3;
  localparam logic [5:0] IDX_TEST_FMT = 6'h00;
  localparam logic [5:0] IDX_CLK_GAIN = 6'h04;
  localparam logic [5:0] IDX_PWR_REF = 6'h0A;
  localparam logic [5:0] IDX_USER_LOW = 6'h0B;
  localparam logic [10:0] REG_RESET = 11'h000;
  localparam logic [10:0] MASK_TEST_FMT = 11'h2E0;
  localparam logic [10:0] MASK_CLK_GAIN = 11'h07C;
  localparam logic [10:0] MASK_PWR_REF = 11'h030;
  localparam logic [10:0] MASK_USER_LOW = 11'h7FF;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int BIT_CHD_PDN = 4;
  localparam int BIT_REF_EXT = 5;
  localparam int BIT_SW_RST = 10;
  localparam int BIT_FMT = 9;
  localparam int GAIN_LSB = 2;
  localparam int PAT_LSB = 5;
  // ----------------------------------------
  // encodings
  // ----------------------------------------
  localparam logic [4:0] GAIN_CODE_0 = 5'h18;
  localparam logic [4:0] GAIN_CODE_1 = 5'h00;
  localparam logic [4:0] GAIN_CODE_2 = 5'h0C;
  localparam logic [4:0] GAIN_CODE_3 = 5'h0A;
  localparam logic [4:0] GAIN_CODE_4 = 5'h09;
  localparam logic [4:0] GAIN_CODE_5 = 5'h08;
  localparam logic [2:0] PAT_NORMAL = 3'h0;
  localparam logic [2:0] PAT_ZEROS = 3'h1;
  localparam logic [2:0] PAT_ONES = 3'h2;
  localparam logic [2:0] PAT_TOGGLE = 3'h3;
  localparam logic [2:0] PAT_UNUSED = 3'h4;
  localparam logic [2:0] PAT_CUSTOM = 3'h5;
  localparam logic [2:0] PAT_ALTERNATING_BIT_SEQUENCE = 3'h6;
  localparam logic [2:0] PAT_SYNC = 3'h7;
  localparam logic [13:0] WORD_ALTERNATING_BIT_SEQUENCE = 14'h2AAA;
  localparam logic [13:0] WORD_TOGGLE = 14'h2AAA;
  localparam logic [13:0] WORD_SYNC = 14'h3F80;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic awvalid; logic [7:0] awaddr;
    logic wvalid; logic [31:0] wdata; logic [3:0] wstrb;
    logic bready;
    logic arvalid; logic [7:0] araddr;
    logic rready;
  } qac_axi_req_type;
  typedef struct packed {
    logic awready; logic wready;
    logic bvalid; logic [1:0] bresp;
    logic arready;
    logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
  } qac_axi_rsp_type;
  typedef struct packed {
    logic chd_power_down; logic ext_ref_select;
    logic [4:0] input_clock_buffer_gain; logic [2:0] gain_step; logic gain_code_valid;
    logic [2:0] pattern_sel; logic output_number_format;
  } qac_cfg_type;
  typedef struct packed {
    logic [10:0] test_fmt; logic [10:0] clk_gain;
    logic [10:0] pwr_ref; logic [10:0] user_low;
  } qac_regs_type;
  typedef struct packed {
    qac_regs_type regs;
    logic aw_got; logic [7:0] aw_addr;
    logic w_got; logic [10:0] w_data; logic [1:0] w_strb;
    logic bvalid; logic [1:0] bresp;
    logic rvalid; logic [10:0] rdata; logic [1:0] rresp;
  } qac_state_type;
  typedef struct packed {
    logic phase; logic [13:0] word;
  } qac_pat_state_type;
endpackage

// *** rtl/qac_pattern_gen.sv ***
// Purpose: output word select: conversion data or a test pattern
// Assumes: sample_in is two's complement on the aclk domain
// Notes: output word is registered, one cycle after its inputs
`timescale 1ns/10ps
module qac_pattern_gen #(
  parameter int WORD_W = 14
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // controls
  input wire logic [2:0] pattern_sel,
  input wire logic output_number_format,
  input wire logic [qac_pkg::WORD_W-1:0] user_word,
  // data
  input wire logic [qac_pkg::WORD_W-1:0] sample_in,
  output logic [qac_pkg::WORD_W-1:0] data_out
);
  import qac_pkg::*;

  if (WORD_W != qac_pkg::WORD_W) begin : g_chk
    $error("pattern width must match the package word width");
  end

  qac_pat_state_type st;
  qac_pat_state_type next_st;

  // ----------------------------------------
  // pattern select
  // ----------------------------------------
  always_comb begin
    next_st = st;
    next_st.phase = ~st.phase;
    unique case (pattern_sel)
      PAT_NORMAL: begin
        next_st.word = sample_in; // RULE7
        if (output_number_format) begin
          next_st.word[WORD_W-1] = ~sample_in[WORD_W-1]; // RULE10
        end
      end
      PAT_ZEROS: next_st.word = '0; // RULE7
      PAT_ONES: next_st.word = '1; // RULE7
      PAT_TOGGLE: next_st.word = st.phase ? ~WORD_TOGGLE : WORD_TOGGLE; // RULE7
      PAT_UNUSED: next_st.word = '0; // RULE7
      PAT_CUSTOM: next_st.word = user_word; // RULE8
      PAT_ALTERNATING_BIT_SEQUENCE: next_st.word = WORD_ALTERNATING_BIT_SEQUENCE; // RULE9
      PAT_SYNC: next_st.word = WORD_SYNC; // RULE7
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign data_out = st.word;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  fmt_offset_a: assert property (pattern_sel == PAT_NORMAL && output_number_format |=> // RULE10
    data_out == {~$past(sample_in[WORD_W-1]), $past(sample_in[WORD_W-2:0])})
    else $error("offset binary output wrong");
  fmt_twos_a: assert property (pattern_sel == PAT_NORMAL && !output_number_format |=> // RULE10
    data_out == $past(sample_in))
    else $error("two's complement output wrong");
  custom_word_a: assert property (pattern_sel == PAT_CUSTOM |=> // RULE8
    data_out == $past(user_word))
    else $error("custom word not output");
  alternating_bit_sequence_word_a: assert property (pattern_sel == PAT_ALTERNATING_BIT_SEQUENCE [*2] |-> // RULE9
    data_out == WORD_ALTERNATING_BIT_SEQUENCE && $past(data_out) != ~WORD_ALTERNATING_BIT_SEQUENCE)
    else $error("alternating sequence wrong");
  toggle_word_a: assert property (pattern_sel == PAT_TOGGLE [*2] |=> // RULE7
    data_out == ~$past(data_out))
    else $error("toggle word did not toggle");
  cover_alternating_bit_sequence_c: cover property (pattern_sel == PAT_ALTERNATING_BIT_SEQUENCE [*3]);
  cover_custom_c: cover property (pattern_sel == PAT_CUSTOM ##1 pattern_sel == PAT_NORMAL);
endmodule

// *** rtl/qac_config_bank.sv ***
// Purpose: configuration register bank of a four-channel converter
// Assumes: AXI4-Lite slave, one write and one read at most in flight
// Notes: registers are 11 bits wide in the low bits of each word
// Function
// RULE1 - channel D sleep bit D4 at 1 powers channel D down, at 0 keeps it up.
// RULE2 - reference bit D5 picks the internal reference at 0, external at 1.
// RULE3 - a 1 written to bit D10 resets every register and the bit clears itself.
// RULE4 - after hardware or software reset every register bit reads 0.
// RULE5 - clock buffer gain sits in D6..D2 of register 0x04, reset code 00000 is step 1.
// RULE6 - gain codes 11000,01100,01010,01001,01000 give steps 0,2,3,4,5.
// RULE7 - test select D7..D5: 000 normal, 001 zeros, 010 ones, 011 toggle, 111 sync, 100 unused.
// RULE8 - test select 101 sends the user word from registers 0x0B and 0x0C; here the top 3 bits come from input user_word_high.
// RULE9 - test select 110 sends a steady 1010 alternating stream.
// RULE10 - format bit D9 picks two's complement at 0, offset binary at 1.
// RULE11 - register 0x0B holds the lower 11 bits of the user word in D10..D0.
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module qac_config_bank (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire qac_pkg::qac_axi_req_type axi_req,
  output qac_pkg::qac_axi_rsp_type axi_rsp,
  // converter side
  input wire logic [qac_pkg::WORD_W-1:0] sample_in,
  input wire logic [qac_pkg::UP_W-1:0] user_word_high,
  output qac_pkg::qac_cfg_type cfg,
  output logic [qac_pkg::WORD_W-1:0] data_out
);
  import qac_pkg::*;

  qac_state_type st;
  qac_state_type next_st;
  logic wr_fire;
  logic [5:0] wr_idx;
  logic [5:0] rd_idx;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic reg_hit(input logic [7:0] addr);
    logic [5:0] idx;
    idx = addr[7:2];
    reg_hit = (addr[1:0] == 2'h0) &&
      (idx == IDX_TEST_FMT || idx == IDX_CLK_GAIN ||
       idx == IDX_PWR_REF || idx == IDX_USER_LOW);
  endfunction

  function automatic logic [10:0] merge(
    input logic [10:0] old,
    input logic [10:0] data,
    input logic [1:0] strb,
    input logic [10:0] mask
  );
    logic [10:0] res;
    res = old;
    if (strb[0]) begin
      res[7:0] = data[7:0];
    end
    if (strb[1]) begin
      res[10:8] = data[10:8];
    end
    merge = res & mask;
  endfunction

  function automatic logic [3:0] gain_decode(input logic [4:0] code);
    logic [3:0] res;
    res = 4'h0;
    unique case (code)
      GAIN_CODE_0: res = {1'b1, 3'h0};
      GAIN_CODE_1: res = {1'b1, 3'h1};
      GAIN_CODE_2: res = {1'b1, 3'h2};
      GAIN_CODE_3: res = {1'b1, 3'h3};
      GAIN_CODE_4: res = {1'b1, 3'h4};
      GAIN_CODE_5: res = {1'b1, 3'h5};
      default: res = 4'h0;
    endcase
    gain_decode = res;
  endfunction

  function automatic logic [10:0] read_reg(
    input qac_regs_type regs,
    input logic [5:0] idx
  );
    logic [10:0] res;
    res = REG_RESET;
    if (idx == IDX_TEST_FMT) begin
      res = regs.test_fmt;
    end else if (idx == IDX_CLK_GAIN) begin
      res = regs.clk_gain;
    end else if (idx == IDX_PWR_REF) begin
      res = regs.pwr_ref;
    end else if (idx == IDX_USER_LOW) begin
      res = regs.user_low;
    end
    read_reg = res;
  endfunction

  // ----------------------------------------
  // handshakes
  // ----------------------------------------
  assign wr_fire = st.aw_got && st.w_got;
  assign wr_idx = st.aw_addr[7:2];
  assign rd_idx = axi_req.araddr[7:2];

  always_comb begin
    axi_rsp.awready = !st.aw_got && !st.bvalid;
    axi_rsp.wready = !st.w_got && !st.bvalid;
    axi_rsp.bvalid = st.bvalid;
    axi_rsp.bresp = st.bresp;
    axi_rsp.arready = !st.rvalid;
    axi_rsp.rvalid = st.rvalid;
    axi_rsp.rdata = {21'h0, st.rdata};
    axi_rsp.rresp = st.rresp;
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_st = st;
    // write address and data, either order
    if (axi_req.awvalid && axi_rsp.awready) begin
      next_st.aw_got = 1'b1;
      next_st.aw_addr = axi_req.awaddr;
    end
    if (axi_req.wvalid && axi_rsp.wready) begin
      next_st.w_got = 1'b1;
      next_st.w_data = axi_req.wdata[10:0];
      next_st.w_strb = axi_req.wstrb[1:0];
    end
    // write response retires first
    if (st.bvalid && axi_req.bready) begin
      next_st.bvalid = 1'b0;
    end
    // register update once both halves are held
    if (wr_fire) begin
      next_st.aw_got = 1'b0;
      next_st.w_got = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = reg_hit(st.aw_addr) ? RESP_OKAY : RESP_SLVERR;
      if (reg_hit(st.aw_addr)) begin
        if (wr_idx == IDX_TEST_FMT) begin
          next_st.regs.test_fmt = merge(st.regs.test_fmt, st.w_data, st.w_strb,
            MASK_TEST_FMT); // RULE7
        end else if (wr_idx == IDX_CLK_GAIN) begin
          next_st.regs.clk_gain = merge(st.regs.clk_gain, st.w_data, st.w_strb,
            MASK_CLK_GAIN); // RULE5
        end else if (wr_idx == IDX_USER_LOW) begin
          next_st.regs.user_low = merge(st.regs.user_low, st.w_data, st.w_strb,
            MASK_USER_LOW); // RULE11
        end else if (st.w_strb[1] && st.w_data[BIT_SW_RST]) begin
          next_st.regs = '0; // RULE3
        end else begin
          next_st.regs.pwr_ref = merge(st.regs.pwr_ref, st.w_data, st.w_strb,
            MASK_PWR_REF); // RULE1
        end
      end
    end
    // read response retires, then a new read is taken
    if (st.rvalid && axi_req.rready) begin
      next_st.rvalid = 1'b0;
    end
    if (axi_req.arvalid && axi_rsp.arready) begin
      next_st.rvalid = 1'b1;
      next_st.rdata = reg_hit(axi_req.araddr) ? read_reg(st.regs, rd_idx) : REG_RESET;
      next_st.rresp = reg_hit(axi_req.araddr) ? RESP_OKAY : RESP_SLVERR;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0; // RULE4
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // configuration outputs
  // ----------------------------------------
  always_comb begin
    cfg.chd_power_down = st.regs.pwr_ref[BIT_CHD_PDN]; // RULE1
    cfg.ext_ref_select = st.regs.pwr_ref[BIT_REF_EXT]; // RULE2
    cfg.input_clock_buffer_gain = st.regs.clk_gain[GAIN_LSB+4:GAIN_LSB]; // RULE5
    {cfg.gain_code_valid, cfg.gain_step} =
      gain_decode(st.regs.clk_gain[GAIN_LSB+4:GAIN_LSB]); // RULE6
    cfg.pattern_sel = st.regs.test_fmt[PAT_LSB+2:PAT_LSB]; // RULE7
    cfg.output_number_format = st.regs.test_fmt[BIT_FMT]; // RULE10
  end

  // ----------------------------------------
  // output word
  // ----------------------------------------
  qac_pattern_gen #(
    .WORD_W(WORD_W)
  ) u_pattern (
    .aclk(aclk),
    .aresetn(aresetn),
    .pattern_sel(cfg.pattern_sel),
    .output_number_format(cfg.output_number_format),
    .user_word({user_word_high, st.regs.user_low}), // RULE8
    .sample_in(sample_in),
    .data_out(data_out)
  );

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_field_write(logic [5:0] idx, int bitpos);
    wr_fire && reg_hit(st.aw_addr) && wr_idx == idx && st.w_strb[0] &&
      !(st.w_strb[1] && st.w_data[BIT_SW_RST]) |=>
      st.regs.pwr_ref[bitpos] == $past(st.w_data[bitpos]);
  endproperty

  chd_sleep_a: assert property (p_field_write(IDX_PWR_REF, BIT_CHD_PDN)) // RULE1
    else $error("channel D sleep bit not stored");
  chd_follow_a: assert property (cfg.chd_power_down == st.regs.pwr_ref[BIT_CHD_PDN] && // RULE1
    !(cfg.chd_power_down && st.regs.pwr_ref[BIT_CHD_PDN] == 1'b0))
    else $error("channel D power down mismatch");
  ref_select_a: assert property (p_field_write(IDX_PWR_REF, BIT_REF_EXT)) // RULE2
    else $error("reference select not stored");
  soft_reset_a: assert property (wr_fire && reg_hit(st.aw_addr) && wr_idx == IDX_PWR_REF && // RULE3
    st.w_strb[1] && st.w_data[BIT_SW_RST] |=> st.regs == '0 && st.bvalid)
    else $error("software reset did not clear registers");
  self_clear_a: assert property (!st.regs.pwr_ref[BIT_SW_RST]) // RULE3
    else $error("software reset bit did not clear");
  hw_reset_a: assert property (!$past(aresetn) |-> st.regs == '0 && data_out == '0) // RULE4
    else $error("registers not zero after reset");
  gain_default_a: assert property (st.regs.clk_gain == REG_RESET |-> // RULE5
    cfg.gain_step == 3'h1 && cfg.gain_code_valid)
    else $error("default gain step wrong");
  gain_map_a: assert property (cfg.input_clock_buffer_gain == GAIN_CODE_0 |-> // RULE6
    cfg.gain_step == 3'h0 && cfg.gain_code_valid)
    else $error("lowest gain step wrong");
  gain_top_a: assert property (cfg.input_clock_buffer_gain == GAIN_CODE_5 |-> // RULE6
    cfg.gain_step == 3'h5)
    else $error("highest gain step wrong");
  user_low_a: assert property (wr_fire && reg_hit(st.aw_addr) && wr_idx == IDX_USER_LOW && // RULE11
    st.w_strb == 2'h3 |=> st.regs.user_low == $past(st.w_data))
    else $error("user word low bits not stored");
  write_resp_a: assert property (axi_req.awvalid && axi_rsp.awready && // RULE4
    axi_req.wvalid && axi_rsp.wready |=> ##1 st.bvalid)
    else $error("write response late");
  read_resp_a: assert property (axi_req.arvalid && axi_rsp.arready |=> // RULE4
    st.rvalid && st.rdata == $past(reg_hit(axi_req.araddr) ?
      read_reg(st.regs, rd_idx) : REG_RESET))
    else $error("read data wrong");

  cover_soft_reset_c: cover property (wr_fire && wr_idx == IDX_PWR_REF &&
    st.w_data[BIT_SW_RST]);
  cover_read_c: cover property (st.rvalid && axi_req.rready && st.rdata != '0);
  cover_bad_addr_c: cover property (st.bvalid && st.bresp == RESP_SLVERR);
endmodule

// *** tb/qac_tb.sv ***
// Purpose: self-checking bench of the converter config bank
// Assumes: bench acts as AXI4-Lite master
// Notes: handshakes sampled at falling edge, driven after rising edge
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin error_cnt++; \
  $display("unexpected %s: expected %h, seen %h", nm, exp, got); end end
module testbench;
  import qac_pkg::*;
  // ----
  // signals
  // ----
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  qac_axi_req_type req = '0;
  qac_axi_rsp_type rsp;
  logic [WORD_W-1:0] sample_in = '0;
  logic [UP_W-1:0] user_word_high = '0;
  qac_cfg_type cfg;
  logic [WORD_W-1:0] data_out;
  int error_cnt = 0;
  int comparisons = 0;
  logic [1:0] resp;
  logic [31:0] rd;
  always #25 aclk = ~aclk;
  qac_config_bank DUT (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
    .sample_in(sample_in), .user_word_high(user_word_high), .cfg(cfg),
    .data_out(data_out));
  // ----
  // bus tasks
  // ----
  task end_sim;
    $display("mismatches %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task axi_write(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic aw_hs, w_hs, b_hs;
    n = 0;
    b_hs = 1'b0;
    @(posedge aclk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.bready <= 1'b1;
    while (!b_hs) begin
      @(negedge aclk);
      aw_hs = req.awvalid && rsp.awready;
      w_hs = req.wvalid && rsp.wready;
      b_hs = rsp.bvalid;
      resp = rsp.bresp;
      @(posedge aclk);
      if (aw_hs) req.awvalid <= 1'b0;
      if (w_hs) req.wvalid <= 1'b0;
      if (b_hs) req.bready <= 1'b0;
      n++;
      if (n > 40) begin
        error_cnt++;
        end_sim();
      end
    end
  endtask
  task axi_read(input logic [7:0] a);
    int n;
    logic ar_hs, r_hs;
    n = 0;
    r_hs = 1'b0;
    @(posedge aclk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    while (!r_hs) begin
      @(negedge aclk);
      ar_hs = req.arvalid && rsp.arready;
      r_hs = rsp.rvalid;
      rd = rsp.rdata;
      resp = rsp.rresp;
      @(posedge aclk);
      if (ar_hs) req.arvalid <= 1'b0;
      if (r_hs) req.rready <= 1'b0;
      n++;
      if (n > 40) begin
        error_cnt++;
        end_sim();
      end
    end
  endtask
  task rd_chk(input logic [7:0] a, input logic [31:0] exp, input string nm);
    axi_read(a);
    `CHK(nm, exp, rd)
  endtask
  task check_pat(input logic [2:0] c, input logic f, input logic [13:0] exp, input string nm);
    axi_write(8'h00, {22'h0, f, 1'b0, c, 5'h0});
    repeat (3) @(posedge aclk);
    @(negedge aclk);
    `CHK(nm, exp, data_out)
  endtask
  // ----
  // scenarios
  // ----
  task t_reset_vals;
    rd_chk(8'h00, 32'h0, "test_fmt reset");
    rd_chk(8'h10, 32'h0, "clk_gain reset");
    rd_chk(8'h28, 32'h0, "pwr_ref reset");
    rd_chk(8'h2C, 32'h0, "user_low reset");
    `CHK("gain step reset", 3'h1, cfg.gain_step)
    `CHK("gain valid reset", 1'b1, cfg.gain_code_valid)
  endtask
  task t_unmapped;
    axi_write(8'h08, 32'h7FF);
    `CHK("bresp unmapped", RESP_SLVERR, resp)
    axi_write(8'h01, 32'h7FF);
    `CHK("bresp unaligned", RESP_SLVERR, resp)
    rd_chk(8'h08, 32'h0, "rdata unmapped");
    `CHK("rresp unmapped", RESP_SLVERR, resp)
    rd_chk(8'h00, 32'h0, "no store");
  endtask
  task t_rw_fields;
    axi_write(8'h00, 32'hFFFFFFFF);
    `CHK("bresp okay", RESP_OKAY, resp)
    rd_chk(8'h00, 32'h2E0, "test_fmt bits");
    `CHK("pattern sel", 3'h7, cfg.pattern_sel)
    `CHK("format bit", 1'b1, cfg.output_number_format)
    axi_write(8'h10, 32'hFFFFFFFF);
    rd_chk(8'h10, 32'h7C, "gain bits");
    `CHK("gain raw", 5'h1F, cfg.input_clock_buffer_gain)
    axi_write(8'h2C, 32'hFFFFFFFF);
    rd_chk(8'h2C, 32'h7FF, "user_low bits");
    axi_write(8'h28, 32'h10);
    rd_chk(8'h28, 32'h10, "power down bit");
    `CHK("chd down", 1'b1, cfg.chd_power_down)
    `CHK("int ref", 1'b0, cfg.ext_ref_select)
    axi_write(8'h28, 32'h20);
    rd_chk(8'h28, 32'h20, "ref bit");
    `CHK("chd up", 1'b0, cfg.chd_power_down)
    `CHK("ext ref", 1'b1, cfg.ext_ref_select)
    axi_write(8'h00, 32'h0);
    `CHK("format 2s", 1'b0, cfg.output_number_format)
  endtask
  task t_gain;
    logic [4:0] codes [6];
    codes = '{5'h18, 5'h00, 5'h0C, 5'h0A, 5'h09, 5'h08};
    for (int i = 0; i < 6; i++) begin
      axi_write(8'h10, {25'h0, codes[i], 2'h0});
      repeat (2) @(posedge aclk);
      @(negedge aclk);
      `CHK("gain step", 3'(i), cfg.gain_step)
      `CHK("gain valid", 1'b1, cfg.gain_code_valid)
    end
    axi_write(8'h10, 32'h7C);
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    `CHK("gain invalid", 1'b0, cfg.gain_code_valid)
  endtask
  task t_patterns;
    logic [13:0] w0;
    sample_in <= 14'h1234;
    user_word_high <= 3'h5;
    axi_write(8'h2C, 32'h5A5);
    check_pat(3'h0, 1'b0, 14'h1234, "normal");
    check_pat(3'h0, 1'b1, 14'h3234, "offset binary");
    check_pat(3'h1, 1'b0, 14'h0000, "zeros");
    check_pat(3'h2, 1'b0, 14'h3FFF, "ones");
    check_pat(3'h4, 1'b0, 14'h0000, "unused");
    check_pat(3'h5, 1'b0, 14'h2DA5, "custom");
    check_pat(3'h7, 1'b0, WORD_SYNC, "sync");
    check_pat(3'h6, 1'b0, WORD_ALTERNATING_BIT_SEQUENCE, "alternating");
    @(negedge aclk);
    `CHK("alternating steady", WORD_ALTERNATING_BIT_SEQUENCE, data_out)
    axi_write(8'h00, 32'h60);
    repeat (3) @(posedge aclk);
    @(negedge aclk);
    w0 = data_out;
    `CHK("toggle start", 1'b1, (w0 == WORD_TOGGLE) || (w0 == ~WORD_TOGGLE))
    @(negedge aclk);
    `CHK("toggle", w0 ^ 14'h3FFF, data_out)
  endtask
  task t_sw_reset;
    axi_write(8'h00, 32'h2E0);
    axi_write(8'h10, 32'h60);
    axi_write(8'h2C, 32'h123);
    axi_write(8'h28, 32'h10);
    axi_write(8'h28, 32'h410);
    `CHK("bresp reset", RESP_OKAY, resp)
    rd_chk(8'h00, 32'h0, "test_fmt soft");
    rd_chk(8'h10, 32'h0, "clk_gain soft");
    rd_chk(8'h2C, 32'h0, "user_low soft");
    rd_chk(8'h28, 32'h0, "self clear");
    `CHK("chd after soft", 1'b0, cfg.chd_power_down)
  endtask
  task t_hw_reset;
    axi_write(8'h00, 32'h2E0);
    axi_write(8'h2C, 32'h7FF);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(8'h00, 32'h0, "test_fmt hard");
    rd_chk(8'h2C, 32'h0, "user_low hard");
  endtask
  // ----
  // main sequence
  // ----
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset_vals();
    t_unmapped();
    t_rw_fields();
    t_gain();
    t_patterns();
    t_sw_reset();
    t_hw_reset();
    end_sim();
  end
endmodule
